// ===== design/mps_consts.svh
// Behaviour
// - Host sets a six-bit profile number before start; 01 to 63 run that profile.
// - Start with the select inputs at 00 enters sequence-forward mode.
// - Sequence-forward runs the profile after the last one; first from reset is 01.
// - An empty next profile wraps the pointer to 01, run on the same start.
// - Sequence-forward needing an empty profile 01 gives no motion, data error.
// - The pointer follows the last run profile, even an explicit one.
// - Homing, stop, jog, preset, release or any alarm reset the pointer to 00, so sequence-forward next runs 01.
// - With a pendant, leaving external I/O mode or emergency halt resets it.
// - Stop during sequence-forward halts the motion and ends the run.
// - A single-motion profile runs exactly once when selected and started.
// - Linked profiles chain onward through the first profile that is not linked.
// - Chain target is the sum of the chained positions.
// - Linked profiles of opposing directions raise an error.
// - Profile 63 never chains onward; a linked profile 63 runs as single-motion.
// - A chain of five or more profiles raises an error.
// - A push ending a chain runs at the starting speed.
// - Move-complete rises when single or linked positioning finishes.
// - Push reaching thrust raises thrust-reached and not move-complete.
// - Push reaching target without thrust stops with move-complete only.
// - A stalled push holds with no alarm until stop or another start.
// - Rod moved by outside force in a push raises deviation alarm, stops.
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH
`define MPS_SEL_W 6
`define MPS_ENT_W 16
`define MPS_POS_W 12
`define MPS_SUM_W 16
`define MPS_PIN_W 15
`define MPS_SET_BIT 15
`define MPS_FN_HI 14
`define MPS_FN_LO 13
`define MPS_DIR_BIT 12
`define MPS_SEQ_NO 6'h00
`define MPS_FIRST_NO 6'h01
`define MPS_LAST_NO 6'h3F
`define MPS_STAT_ADR 6'h00
`define MPS_MAX_CHAIN 3'h4
`define MPS_CNT_ZERO 3'h0
`define MPS_CNT_ONE 3'h1
`define MPS_IDX_ONE 6'h01
`endif

// ===== design/mps_pkg.sv
package mps_pkg;
  typedef enum logic [1:0] {
    MPS_FN_SINGLE = 2'b00,
    MPS_FN_LINKED = 2'b01,
    MPS_FN_PUSH = 2'b10,
    MPS_FN_RSVD = 2'b11
  } mps_fn_t;
  typedef enum logic [1:0] {
    MPS_ST_IDLE = 2'b00,
    MPS_ST_BUILD = 2'b01,
    MPS_ST_RUN = 2'b10,
    MPS_ST_HOLD = 2'b11
  } mps_state_t;
endpackage

// ===== design/mps_sequencer.sv
`timescale 1ns/100ps
`include "mps_consts.svh"
module mps_sequencer
  import mps_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [`MPS_SEL_W-1:0] profileSelect,
  input wire logic startIn,
  input wire logic stopIn,
  input wire logic homeIn,
  input wire logic jogFwdIn,
  input wire logic jogRvsIn,
  input wire logic presetIn,
  input wire logic releaseIn,
  input wire logic pendantAttached,
  input wire logic externalIoMode,
  input wire logic emergencyHalt,
  input wire logic alarmIn,
  input wire logic motionDone,
  input wire logic thrustUp,
  input wire logic rodDeviation,
  input wire logic [`MPS_SEL_W-1:0] regAddr,
  input wire logic [`MPS_ENT_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`MPS_ENT_W-1:0] regRdData,
  output logic cmdValid,
  output logic [`MPS_SUM_W-1:0] cmdTarget,
  output logic cmdDir,
  output logic cmdPush,
  output logic cmdStartSpeed,
  output logic haltReq,
  output logic moveComplete,
  output logic thrustReached,
  output logic dataError,
  output logic deviationAlarm,
  output logic busy
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [`MPS_PIN_W-1:0] pinMeta_q;
  logic [`MPS_PIN_W-1:0] pinSync_q;
  logic [`MPS_PIN_W-1:0] pinRaw;
  logic [`MPS_SEL_W-1:0] selS;
  logic startS;
  logic stopS;
  logic homeS;
  logic fwdS;
  logic rvsS;
  logic presetS;
  logic releaseS;
  logic pendantS;
  logic ioModeS;
  logic estopS;

  assign pinRaw = {profileSelect, startIn, stopIn, homeIn, jogFwdIn,
                   jogRvsIn, presetIn, releaseIn, pendantAttached,
                   externalIoMode};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
    end
  end

  logic estopMeta_q;
  logic estopSync_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      estopMeta_q <= 1'b0;
      estopSync_q <= 1'b0;
    end else begin
      estopMeta_q <= emergencyHalt;
      estopSync_q <= estopMeta_q;
    end
  end

  assign {selS, startS, stopS, homeS, fwdS, rvsS, presetS, releaseS,
          pendantS, ioModeS} = pinSync_q;
  assign estopS = estopSync_q;

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  logic startPrev_q;
  logic stopPrev_q;
  logic ioModePrev_q;
  logic startRise;
  logic stopRise;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      startPrev_q <= 1'b0;
      stopPrev_q <= 1'b0;
      ioModePrev_q <= 1'b0;
    end else begin
      startPrev_q <= startS;
      stopPrev_q <= stopS;
      ioModePrev_q <= ioModeS;
    end
  end

  assign startRise = startS && !startPrev_q;
  assign stopRise = stopS && !stopPrev_q;

  // ----------------------------------------
  // Profile table
  // ----------------------------------------
  logic [`MPS_ENT_W-1:0] mem [0:63];

  assign mem[0] = '0;

  genvar g;
  generate
    for (g = 1; g < 64; g++) begin : gEnt
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          mem[g] <= '0;
        end else if (regWr && regAddr == `MPS_SEL_W'(g)) begin
          mem[g] <= regWrData;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // State and registers
  // ----------------------------------------
  mps_state_t st_q;
  logic [`MPS_SEL_W-1:0] ptr_q;
  logic [`MPS_SEL_W-1:0] idx_q;
  logic [2:0] cnt_q;
  logic [`MPS_SUM_W-1:0] sum_q;
  logic dir_q;

  // ----------------------------------------
  // Start decode
  // ----------------------------------------
  logic [`MPS_SEL_W:0] seqNext;
  logic seqMode;
  logic nextSet;
  logic firstSet;
  logic startAcc;
  logic startOk;
  logic [`MPS_SEL_W-1:0] startNo;

  assign seqNext = {1'b0, ptr_q} + {1'b0, `MPS_IDX_ONE};
  assign seqMode = selS == `MPS_SEQ_NO;
  assign nextSet = (ptr_q != `MPS_LAST_NO) &&
                   mem[seqNext[`MPS_SEL_W-1:0]][`MPS_SET_BIT];
  assign firstSet = mem[`MPS_FIRST_NO][`MPS_SET_BIT];
  assign startAcc = startRise && st_q != MPS_ST_BUILD;

  always_comb begin
    startOk = 1'b1;
    startNo = selS;
    if (seqMode) begin
      if (nextSet) begin
        startNo = seqNext[`MPS_SEL_W-1:0];
      end else if (firstSet) begin
        startNo = `MPS_FIRST_NO;
      end else begin
        startOk = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Chain build
  // ----------------------------------------
  logic [`MPS_ENT_W-1:0] ent;
  mps_fn_t entFn;
  logic entSet;
  logic entDir;
  logic isLinked;
  logic dirBad;
  logic lenBad;
  logic buildErr;
  logic chainEnd;
  logic issue;
  logic [`MPS_SUM_W-1:0] sumNext;

  assign ent = mem[idx_q];
  assign entFn = mps_fn_t'(ent[`MPS_FN_HI:`MPS_FN_LO]);
  assign entSet = ent[`MPS_SET_BIT];
  assign entDir = ent[`MPS_DIR_BIT];
  assign isLinked = entFn == MPS_FN_LINKED &&
                    idx_q != `MPS_LAST_NO;
  assign dirBad = cnt_q != `MPS_CNT_ZERO && entDir != dir_q;
  assign lenBad = isLinked &&
                  cnt_q == `MPS_MAX_CHAIN - `MPS_CNT_ONE;
  assign buildErr = !entSet || dirBad || lenBad;
  assign chainEnd = !isLinked;
  assign sumNext = sum_q +
                   `MPS_SUM_W'(ent[`MPS_POS_W-1:0]);
  assign issue = st_q == MPS_ST_BUILD && !stopRise &&
                 !buildErr && chainEnd;

  // ----------------------------------------
  // Events
  // ----------------------------------------
  logic running;
  logic devSet;
  logic errSet;
  logic moveSet;
  logic thrSet;
  logic pendantClr;
  logic ptrClr;

  assign running = st_q == MPS_ST_RUN || st_q == MPS_ST_HOLD;
  assign devSet = running && cmdPush && rodDeviation;
  assign errSet = (st_q == MPS_ST_BUILD && !stopRise && buildErr) ||
                  (startAcc && !startOk);
  assign thrSet = st_q == MPS_ST_RUN && cmdPush && thrustUp;
  assign moveSet = st_q == MPS_ST_RUN && motionDone &&
                   !thrSet;
  assign pendantClr = pendantS &&
                      ((ioModePrev_q && !ioModeS) || estopS);
  assign ptrClr = homeS || stopS || fwdS || rvsS || presetS ||
                  releaseS || alarmIn || devSet || errSet ||
                  pendantClr;

  // ----------------------------------------
  // Sequencer state machine
  // ----------------------------------------
  mps_state_t afterStart;

  assign afterStart = startOk ? MPS_ST_BUILD : MPS_ST_IDLE;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= MPS_ST_IDLE;
    end else begin
      unique case (st_q)
        MPS_ST_IDLE: begin
          if (startAcc) begin
            st_q <= afterStart;
          end
        end
        MPS_ST_BUILD: begin
          if (stopRise || buildErr) begin
            st_q <= MPS_ST_IDLE;
          end else if (chainEnd) begin
            st_q <= MPS_ST_RUN;
          end
        end
        MPS_ST_RUN: begin
          if (stopRise || devSet) begin
            st_q <= MPS_ST_IDLE;
          end else if (startAcc) begin
            st_q <= afterStart;
          end else if (thrSet) begin
            st_q <= MPS_ST_HOLD;
          end else if (motionDone) begin
            st_q <= MPS_ST_IDLE;
          end
        end
        MPS_ST_HOLD: begin
          if (stopRise || devSet) begin
            st_q <= MPS_ST_IDLE;
          end else if (startAcc) begin
            st_q <= afterStart;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Chain datapath
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      idx_q <= '0;
      cnt_q <= `MPS_CNT_ZERO;
      sum_q <= '0;
      dir_q <= 1'b0;
    end else if (startAcc) begin
      idx_q <= startNo;
      cnt_q <= `MPS_CNT_ZERO;
      sum_q <= '0;
    end else if (st_q == MPS_ST_BUILD && !buildErr) begin
      cnt_q <= cnt_q + `MPS_CNT_ONE;
      sum_q <= sumNext;
      if (cnt_q == `MPS_CNT_ZERO) begin
        dir_q <= entDir;
      end
      if (!chainEnd) begin
        idx_q <= idx_q + `MPS_IDX_ONE;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ptr_q <= '0;
    end else if (ptrClr) begin
      ptr_q <= '0;
    end else if (issue) begin
      ptr_q <= idx_q;
    end
  end

  // ----------------------------------------
  // Motion command
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmdValid <= 1'b0;
      cmdTarget <= '0;
      cmdDir <= 1'b0;
      cmdPush <= 1'b0;
      cmdStartSpeed <= 1'b0;
    end else begin
      cmdValid <= issue;
      if (issue) begin
        cmdTarget <= sumNext;
        cmdDir <= (cnt_q == `MPS_CNT_ZERO) ? entDir : dir_q;
        cmdPush <= entFn == MPS_FN_PUSH;
        cmdStartSpeed <= entFn == MPS_FN_PUSH &&
                         cnt_q != `MPS_CNT_ZERO;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      haltReq <= 1'b0;
    end else begin
      haltReq <= (stopRise && st_q != MPS_ST_IDLE) ||
                 devSet;
    end
  end

  // ----------------------------------------
  // Result flags
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      moveComplete <= 1'b0;
    end else if (moveSet) begin
      moveComplete <= 1'b1;
    end else if (startAcc || thrSet) begin
      moveComplete <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      thrustReached <= 1'b0;
    end else if (thrSet) begin
      thrustReached <= 1'b1;
    end else if (startAcc || stopRise) begin
      thrustReached <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dataError <= 1'b0;
    end else if (errSet) begin
      dataError <= 1'b1;
    end else if (startAcc) begin
      dataError <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      deviationAlarm <= 1'b0;
    end else if (devSet) begin
      deviationAlarm <= 1'b1;
    end else if (stopRise) begin
      deviationAlarm <= 1'b0;
    end
  end

  assign busy = st_q != MPS_ST_IDLE;

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  logic [`MPS_ENT_W-1:0] status;

  assign status = {dataError, deviationAlarm, moveComplete,
                   thrustReached, 2'h0, st_q, 2'h0, ptr_q};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= '0;
    end else if (regRd) begin
      regRdData <= (regAddr == `MPS_STAT_ADR) ? status : mem[regAddr];
    end else begin
      regRdData <= '0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  chk_sel_sample: assert property (
    startAcc && !seqMode |=> idx_q == $past(selS))
    else $error("profile number not sampled at start");
  chk_seq_first: assert property (
    startAcc && seqMode && ptr_q == '0 && firstSet && !stopRise &&
      !devSet |=>
      st_q == MPS_ST_BUILD && idx_q == `MPS_FIRST_NO)
    else $error("sequence did not begin at profile one");
  chk_seq_next: assert property (
    startAcc && seqMode && nextSet |=>
      idx_q == $past(ptr_q) + `MPS_IDX_ONE)
    else $error("sequence did not advance from pointer");
  chk_seq_wrap: assert property (
    startAcc && seqMode && !nextSet && firstSet |=>
      idx_q == `MPS_FIRST_NO)
    else $error("sequence did not wrap to profile one");
  chk_no_first: assert property (
    startAcc && seqMode && !nextSet && !firstSet |=>
      dataError && st_q == MPS_ST_IDLE ##1 !cmdValid)
    else $error("empty first profile not refused");
  chk_ptr_clear: assert property (
    ptrClr |=> ptr_q == '0)
    else $error("pointer not cleared");
  chk_stop_halt: assert property (
    stopRise && running |=> haltReq && st_q == MPS_ST_IDLE)
    else $error("stop did not halt motion");
  chk_thr_excl: assert property (
    thrSet |=> thrustReached && !moveComplete)
    else $error("thrust and complete both set");
  chk_done_end: assert property (
    moveSet |=> moveComplete && !thrustReached ##1 !thrustReached)
    else $error("move complete missing");
  chk_chain_len: assert property (
    cmdValid |-> cnt_q >= `MPS_CNT_ONE && cnt_q <= `MPS_MAX_CHAIN)
    else $error("chain length out of range");
  chk_last_single: assert property (
    st_q == MPS_ST_BUILD && idx_q == `MPS_LAST_NO |=>
      st_q != MPS_ST_BUILD)
    else $error("profile 63 chained onward");
  chk_push_hold: assert property (
    st_q == MPS_ST_HOLD && !stopRise && !startAcc && !devSet |=>
      st_q == MPS_ST_HOLD && !deviationAlarm)
    else $error("stalled push released");

  cov_seq_wrap: cover property (
    startAcc && seqMode && !nextSet && firstSet);
  cov_chain_four: cover property (
    cmdValid && cnt_q == `MPS_MAX_CHAIN);
  cov_push_hold: cover property (
    st_q == MPS_ST_RUN ##1 st_q == MPS_ST_HOLD);
  cov_dir_err: cover property (
    st_q == MPS_ST_BUILD && dirBad);

endmodule

// ===== tb/mps_engine_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Motion engine stand-in
// ----------------------------------------
// Mode 0 quick finish, 1 slow finish, 2 push reaches thrust,
// 3 push stalls against the load, 4 rod pushed back by outside force
module mps_engine_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cmdValid,
  input wire logic cmdPush,
  input wire logic haltReq,
  input wire logic [2:0] mode,
  output logic motionDone,
  output logic thrustUp,
  output logic rodDeviation
);
  logic actv_q;
  logic push_q;
  logic [6:0] cnt_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      actv_q <= 1'h0;
      push_q <= 1'h0;
      cnt_q <= 7'h00;
      motionDone <= 1'h0;
      thrustUp <= 1'h0;
      rodDeviation <= 1'h0;
    end else begin
      motionDone <= 1'h0;
      thrustUp <= 1'h0;
      rodDeviation <= 1'h0;
      if (haltReq) begin
        actv_q <= 1'h0;
      end else if (cmdValid) begin
        actv_q <= 1'h1;
        push_q <= cmdPush;
        cnt_q <= (mode == 3'h1) ? 7'h3C : 7'h03;
      end else if (actv_q && cnt_q != 7'h00) begin
        cnt_q <= cnt_q - 7'h01;
      end else if (actv_q) begin
        actv_q <= 1'h0;
        if (push_q && mode == 3'h2) begin
          thrustUp <= 1'h1;
        end else if (push_q && mode == 3'h4) begin
          rodDeviation <= 1'h1;
        end else if (!(push_q && mode == 3'h3)) begin
          motionDone <= 1'h1;
        end
      end
    end
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
`define CHK(g, e, m) begin totalChecks++; if ((g) !== (e)) begin \
  errCount++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb;
  typedef struct packed {
    logic err;
    logic [15:0] tgt;
    logic dir;
    logic push;
    logic ss;
  } mps_exp_t;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic [5:0] profileSelect = 6'h00;
  logic startIn = 1'h0;
  logic [8:0] clr = 9'h000;
  logic pend = 1'h1;
  logic [5:0] regAddr = 6'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic [2:0] mode = 3'h0;
  logic motionDone, thrustUp, rodDeviation, cmdValid, cmdDir, cmdPush;
  logic cmdStartSpeed, haltReq, moveComplete, thrustReached, dataError;
  logic deviationAlarm, busy;
  logic [15:0] regRdData, cmdTarget;
  int errCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  int haltCnt = 0;
  int h;
  logic [31:0] seed = 32'hD10A78DD;
  logic [15:0] tbl [64] = '{default: 16'h0000};
  logic [5:0] ptr = 6'h00;
  logic [5:0] lastNo;
  logic d;
  logic errPrev = 1'h0;
  mps_exp_t expQ[$];

  mps_sequencer i_mps_sequencer (
    .core_clk(core_clk), .rstn(rstn), .profileSelect(profileSelect),
    .startIn(startIn), .stopIn(clr[1]), .homeIn(clr[0]),
    .jogFwdIn(clr[2]), .jogRvsIn(clr[3]), .presetIn(clr[4]),
    .releaseIn(clr[5]), .pendantAttached(pend),
    .externalIoMode(~clr[7]), .emergencyHalt(clr[8]), .alarmIn(clr[6]),
    .motionDone(motionDone), .thrustUp(thrustUp),
    .rodDeviation(rodDeviation), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .cmdValid(cmdValid), .cmdTarget(cmdTarget),
    .cmdDir(cmdDir), .cmdPush(cmdPush), .cmdStartSpeed(cmdStartSpeed),
    .haltReq(haltReq), .moveComplete(moveComplete),
    .thrustReached(thrustReached), .dataError(dataError),
    .deviationAlarm(deviationAlarm), .busy(busy)
  );
  mps_engine_model i_mps_engine_model (
    .core_clk(core_clk), .rstn(rstn), .cmdValid(cmdValid),
    .cmdPush(cmdPush), .haltReq(haltReq), .mode(mode),
    .motionDone(motionDone), .thrustUp(thrustUp),
    .rodDeviation(rodDeviation)
  );

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Result watcher and timeout
  // ----------------------------------------
  always @(posedge core_clk) begin
    mps_exp_t e;
    cycles++;
    if (haltReq === 1'h1) haltCnt++;
    if (rstn && (cmdValid === 1'h1 || (dataError === 1'h1 && !errPrev))) begin
      if (expQ.size() == 0) `CHK(1'h1, 1'h0, "unexpected result")
      else begin
        e = expQ.pop_front();
        `CHK(cmdValid !== 1'h1, e.err, "error outcome")
        if (!e.err) begin
          `CHK(cmdTarget, e.tgt, "target")
          `CHK(cmdDir, e.dir, "direction")
          `CHK(cmdPush, e.push, "push flag")
          `CHK(cmdStartSpeed, e.ss, "start speed")
        end
      end
    end
    errPrev <= dataError;
    if (cycles == 40000) begin
      errCount++;
      finishTest();
    end
  end

  task automatic finishTest();
    if (errCount == 0 && totalChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // ----------------------------------------
  // Bus, pin and expectation helpers
  // ----------------------------------------
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge core_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWrData <= v;
    @(posedge core_clk);
    regWr <= 1'h0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] v);
    @(posedge core_clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'h0;
    #1 `CHK(regRdData, v, "read data")
  endtask

  task automatic setE(input logic [5:0] n, input logic [1:0] fn,
                      input logic dr);
    seed = xs(seed);
    tbl[n] = {1'h1, fn, dr, seed[11:0]};
    wr(n, tbl[n]);
  endtask

  function automatic mps_exp_t expOf(input logic [5:0] n);
    mps_exp_t e;
    logic [5:0] i;
    e = '0;
    i = n;
    e.dir = tbl[n][12];
    e.err = 1'h1;
    for (int k = 0; k < 4; k++) begin
      if (tbl[i][15] !== 1'h1 || tbl[i][12] !== e.dir) return e;
      e.tgt = e.tgt + {4'h0, tbl[i][11:0]};
      if (tbl[i][14:13] != 2'h1 || i == 6'h3F) begin
        e.err = 1'h0;
        e.push = tbl[i][14:13] == 2'h2;
        e.ss = e.push && k > 0;
        lastNo = i;
        return e;
      end
      i = i + 6'h01;
    end
    return e;
  endfunction

  // Select changes to alt while the start is already under way
  task automatic go(input logic [5:0] sel, input logic [5:0] alt);
    mps_exp_t e;
    logic [5:0] n;
    n = sel;
    if (sel == 6'h00) begin
      n = (ptr == 6'h3F) ? 6'h01 : ptr + 6'h01;
      if (tbl[n][15] !== 1'h1) n = 6'h01;
    end
    e = expOf(n);
    ptr = e.err ? 6'h00 : lastNo;
    expQ.push_back(e);
    @(posedge core_clk);
    profileSelect <= sel;
    startIn <= 1'h1;
    repeat (3) @(posedge core_clk);
    if (alt != 6'h00) profileSelect <= alt;
    @(posedge core_clk);
    startIn <= 1'h0;
  endtask

  task automatic waitIdle();
    int k;
    k = 0;
    @(posedge core_clk);
    #1;
    while (busy !== 1'h0 && k < 300) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k >= 300) begin
      errCount++;
      $display("CHECK FAILED %0t still busy", $time);
    end
  endtask

  task automatic pin(input int j);
    @(posedge core_clk);
    clr[j] <= 1'h1;
    repeat (3) @(posedge core_clk);
    clr[j] <= 1'h0;
    repeat (5) @(posedge core_clk);
    #1 ptr = 6'h00;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'h1;
    rd(6'h00, 16'h0000);
    wr(6'h00, 16'hFFFF);
    rd(6'h00, 16'h0000);
    go(6'h00, 6'h00);
    waitIdle();
    `CHK(dataError, 1'h1, "empty first profile")
    seed = xs(seed);
    d = seed[31];
    setE(6'h01, 2'h0, d);
    setE(6'h02, 2'h1, d);
    setE(6'h03, 2'h1, d);
    setE(6'h04, 2'h0, d);
    setE(6'h0B, 2'h0, d);
    setE(6'h0C, 2'h3, d);
    for (int i = 20; i < 23; i++) setE(6'(i), 2'h1, d);
    setE(6'h17, 2'h0, d);
    for (int i = 30; i < 35; i++) setE(6'(i), 2'h1, d);
    setE(6'h23, 2'h0, d);
    setE(6'h28, 2'h1, d);
    setE(6'h29, 2'h0, !d);
    // Push entries carry no speed field; host keeps push speed low
    setE(6'h2D, 2'h1, d);
    setE(6'h2E, 2'h2, d);
    setE(6'h32, 2'h2, d);
    setE(6'h3F, 2'h1, d);
    rd(6'h2E, tbl[46]);
    go(6'h00, 6'h00);
    waitIdle();
    `CHK(moveComplete, 1'h1, "end after single")
    `CHK(thrustReached, 1'h0, "no thrust on positioning")
    go(6'h00, 6'h00);
    waitIdle();
    go(6'h00, 6'h00);
    waitIdle();
    go(6'h0B, 6'h00);
    waitIdle();
    go(6'h00, 6'h00);
    waitIdle();
    go(6'h00, 6'h00);
    waitIdle();
    rd(6'h00, {10'h080, ptr});
    for (int j = 0; j < 9; j++) begin
      pin(j);
      go(6'h00, 6'h00);
      waitIdle();
    end
    // Without a pendant, leaving external I/O mode keeps the pointer
    @(posedge core_clk);
    pend <= 1'h0;
    pin(7);
    ptr = 6'h01;
    @(posedge core_clk);
    pend <= 1'h1;
    go(6'h00, 6'h00);
    waitIdle();
    go(6'h14, 6'h00);
    waitIdle();
    go(6'h1E, 6'h00);
    waitIdle();
    go(6'h01, 6'h00);
    waitIdle();
    go(6'h28, 6'h00);
    waitIdle();
    go(6'h3F, 6'h00);
    waitIdle();
    go(6'h04, 6'h0B);
    waitIdle();
    mode = 3'h2;
    go(6'h32, 6'h00);
    repeat (12) @(posedge core_clk);
    #1 `CHK(thrustReached, 1'h1, "thrust flag")
    `CHK(moveComplete, 1'h0, "no end on thrust")
    h = haltCnt;
    pin(1);
    `CHK(haltCnt, h + 1, "halt on stop in hold")
    `CHK(thrustReached, 1'h0, "thrust flag cleared")
    mode = 3'h0;
    go(6'h32, 6'h00);
    waitIdle();
    `CHK(moveComplete, 1'h1, "push ends at target")
    `CHK(thrustReached, 1'h0, "no thrust at target")
    mode = 3'h3;
    go(6'h32, 6'h00);
    repeat (60) @(posedge core_clk);
    #1 `CHK(busy, 1'h1, "stall holds")
    `CHK(deviationAlarm, 1'h0, "stall raises no alarm")
    mode = 3'h0;
    go(6'h01, 6'h00);
    waitIdle();
    mode = 3'h4;
    h = haltCnt;
    go(6'h32, 6'h00);
    waitIdle();
    repeat (2) @(posedge core_clk);
    #1 `CHK(deviationAlarm, 1'h1, "deviation alarm")
    `CHK(haltCnt, h + 1, "motor stopped")
    ptr = 6'h00;
    pin(1);
    mode = 3'h0;
    go(6'h2D, 6'h00);
    waitIdle();
    mode = 3'h1;
    go(6'h00, 6'h00);
    h = haltCnt;
    pin(1);
    `CHK(haltCnt, h + 1, "stop halts sequence run")
    repeat (70) @(posedge core_clk);
    #1 `CHK(moveComplete, 1'h0, "halted run not complete")
    mode = 3'h0;
    go(6'h00, 6'h00);
    waitIdle();
    `CHK(expQ.size(), 0, "results outstanding")
    finishTest();
  end
endmodule
